// ==== src/uocs_consts.svh ====
/*
 constant macros of the usb otg control/status block: register offsets, field positions,
 reset values and timing counts. assumes a 100 mhz module clock.
*/
`ifndef UOCS_CONSTS_SVH
`define UOCS_CONSTS_SVH

// register byte addresses on the wishbone slave
`define UOCS_OFS_PWRC 8'h00
`define UOCS_OFS_STAT 8'h04
`define UOCS_OFS_CON 8'h08
`define UOCS_OFS_ADDR 8'h0c
`define UOCS_OFS_TOK 8'h10
`define UOCS_OFS_SOF 8'h14
`define UOCS_OFS_LINK 8'h18

// power control field positions
`define UOCS_PWR_ACT 7
`define UOCS_PWR_GRD 4
`define UOCS_PWR_SUSP 1
`define UOCS_PWR_EN 0

// control and address field positions
`define UOCS_CON_JST 7
`define UOCS_CON_SE0 6
`define UOCS_CON_PKT 5
`define UOCS_CON_RST 4
`define UOCS_CON_HOST 3
`define UOCS_CON_RES 2
`define UOCS_CON_PPR 1
`define UOCS_CON_EN 0
`define UOCS_ADDR_LS 7

// token codes
`define UOCS_PID_SETUP 4'hd
`define UOCS_PID_IN 4'h9
`define UOCS_PID_OUT 4'h1

// reset values
`define UOCS_SOF_RST 8'h00
`define UOCS_OTG_RST 1'b0

// timing
`define UOCS_CLK_MHZ 100
`define UOCS_FRAME_US 1000
`define UOCS_FRAME_CYC (`UOCS_FRAME_US * `UOCS_CLK_MHZ)

`endif

// ==== src/uocs_pkg.sv ====
/*
 types of the usb otg control/status block.
 assumes uocs_consts.svh is not needed here; only types live in this package.
*/
`default_nettype none
package uocs_pkg;
   typedef enum logic [1:0] {
      UOCS_TK_IDLE = 2'b00,
      UOCS_TK_RUN = 2'b01,
      UOCS_TK_DONE = 2'b11
   } uocs_tok_e;

   // one finished transfer reported by the serial engine
   typedef struct packed {
      logic valid;
      logic [3:0] endpoint;
      logic transmit;
      logic odd_bank;
      logic setup_token;
   } uocs_xfer_s;

   // line state seen by the receiver
   typedef struct packed {
      logic se0;
      logic diff_one;
   } uocs_line_s;

   // control outputs toward engine and transceiver
   typedef struct packed {
      logic clock_gate;
      logic xcvr_low_power;
      logic dp_pullup;
      logic dp_pulldown;
      logic dm_pulldown;
      logic resume_drive;
      logic bus_reset_drive;
      logic packet_halt;
      logic low_speed;
      logic pingpong_clear;
      logic sof_pulse;
   } uocs_ctl_s;

   // host token issue
   typedef struct packed {
      logic start;
      logic [3:0] pid;
      logic [3:0] endpoint;
      logic [6:0] address;
   } uocs_tok_s;

   // all state of the block
   typedef struct packed {
      logic power_enable;
      logic sleep_guard;
      logic suspend_enable;
      logic packet_halt;
      logic host_enable;
      logic resume;
      logic bus_reset;
      logic attach_or_sof;
      logic low_speed;
      logic [6:0] function_address;
      logic [3:0] token_pid;
      logic [3:0] token_endpoint;
      logic [7:0] threshold;
      logic [3:0] last_endpoint;
      logic last_transmit;
      logic last_odd;
      uocs_tok_e tok_state;
      logic tok_start;
      logic pp_clear;
      logic [16:0] frame_cnt;
      logic sof_pulse;
      logic ack;
      logic [31:0] rdata;
   } uocs_state_s;
endpackage : uocs_pkg
`default_nettype wire

// ==== src/uocs_top.sv ====
/*
 control and status registers of a dual-role usb otg module, with a classic wishbone slave.
 assumes a serial engine reports finished transfers and token completion, and a transceiver
 reports the live line state; all inputs synchronous to clk.
*/
// Functional notes
// - activity pending high while guarded and module busy, low when suspend safe
// - suspend enable gates usb clock and puts transceiver in low power
// - last transfer records four-bit endpoint number, 0 to 15
// - status direction bit: one transmit, zero receive
// - status bank bit: one odd, zero even; valid for ping-pong endpoints
// - live read-only single-ended-zero flag in both modes
// - packet halt set by hardware on setup token in device mode, cleared by software
// - host enable switches on d+ and d- pull-downs unless dual-role control is on
// - resume bit drives resume signaling; software holds it 10 ms
// - writing one to ping-pong clear resets all pointers to even bank
// - device attach enable turns on d+ pull-up while power enable set and dual-role control off; module itself follows power enable
// - host mode live j-state flag, polarity per speed
// - token busy set while a token executes in host mode
// - host bus reset driven while reset bit set; software holds 50 ms
// - host sends frame token every millisecond while frame enable set and suspend enable clear
// - low speed select only in host mode, reads zero in device mode
// - seven-bit function address in low seven bits
// - frame threshold equals ten plus packet size in bytes
`include "uocs_consts.svh"
`default_nettype none
module uocs_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire uocs_pkg::uocs_xfer_s xfer_i,
   input wire uocs_pkg::uocs_line_s line_i,
   input wire logic engine_busy_i,
   input wire logic token_done_i,
   input wire logic dual_role_enable_i,
   output uocs_pkg::uocs_ctl_s ctl_o,
   output uocs_pkg::uocs_tok_s tok_o,
   output logic [7:0] frame_threshold_o,
   output logic token_in_progress_o,
   output logic activity_pending_o
);
   uocs_pkg::uocs_state_s st_ff;
   uocs_pkg::uocs_state_s nxt_st;
   logic wr;
   logic rd;
   logic live_se0;
   logic live_live_idle_state_flag;
   logic tok_busy;
   logic act_pend;

   // register byte write into low lane only; upper bits unimplemented
   function automatic logic [7:0] uocs_merge(input logic [7:0] old, input logic [31:0] d,
                                             input logic [3:0] sel);
      uocs_merge = sel[0] ? d[7:0] : old;
   endfunction : uocs_merge

   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack;
   assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st_ff.ack;
   assign live_se0 = line_i.se0;
   // j is differential one at full speed, zero at low speed
   assign live_live_idle_state_flag = st_ff.host_enable && !line_i.se0 &&
                        (line_i.diff_one ^ st_ff.low_speed);
   assign tok_busy = st_ff.host_enable && (st_ff.tok_state != uocs_pkg::UOCS_TK_IDLE);
   // only meaningful while guarded; busy engine or running token blocks suspend
   assign act_pend = st_ff.sleep_guard && (engine_busy_i || tok_busy || xfer_i.valid);

   // next state: register writes, hardware updates, token and frame timers
   always_comb begin
      logic [7:0] wd;
      wd = 8'h00;
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.tok_start = 1'b0;
      nxt_st.pp_clear = 1'b0;
      nxt_st.sof_pulse = 1'b0;
      if (wr || rd) begin
         nxt_st.ack = 1'b1;
      end
      // transfer results; a setup token arms the halt in device mode
      if (xfer_i.valid) begin
         nxt_st.last_endpoint = xfer_i.endpoint;
         nxt_st.last_transmit = xfer_i.transmit;
         nxt_st.last_odd = xfer_i.odd_bank;
      end
      if (wr) begin
         case (wb_adr_i)
            `UOCS_OFS_PWRC: begin
               wd = uocs_merge({st_ff.sleep_guard, 2'b00, st_ff.sleep_guard, 2'b00,
                                st_ff.suspend_enable, st_ff.power_enable}, wb_dat_i, wb_sel_i);
               nxt_st.sleep_guard = wd[`UOCS_PWR_GRD];
               nxt_st.suspend_enable = wd[`UOCS_PWR_SUSP];
               nxt_st.power_enable = wd[`UOCS_PWR_EN];
            end
            `UOCS_OFS_CON: begin
               if (wb_sel_i[0]) begin
                  nxt_st.packet_halt = wb_dat_i[`UOCS_CON_PKT];
                  nxt_st.bus_reset = wb_dat_i[`UOCS_CON_RST];
                  nxt_st.host_enable = wb_dat_i[`UOCS_CON_HOST];
                  nxt_st.resume = wb_dat_i[`UOCS_CON_RES];
                  nxt_st.pp_clear = wb_dat_i[`UOCS_CON_PPR];
                  nxt_st.attach_or_sof = wb_dat_i[`UOCS_CON_EN];
               end
            end
            `UOCS_OFS_ADDR: begin
               if (wb_sel_i[0]) begin
                  nxt_st.low_speed = wb_dat_i[`UOCS_ADDR_LS];
                  nxt_st.function_address = wb_dat_i[6:0];
               end
            end
            `UOCS_OFS_TOK: begin
               if (wb_sel_i[0]) begin
                  nxt_st.token_pid = wb_dat_i[7:4];
                  nxt_st.token_endpoint = wb_dat_i[3:0];
                  // a write while a token runs is held off: fields change, no restart
                  if (st_ff.host_enable && st_ff.tok_state == uocs_pkg::UOCS_TK_IDLE) begin
                     nxt_st.tok_start = 1'b1;
                     nxt_st.tok_state = uocs_pkg::UOCS_TK_RUN;
                  end
               end
            end
            `UOCS_OFS_SOF: begin
               nxt_st.threshold = uocs_merge(st_ff.threshold, wb_dat_i, wb_sel_i);
            end
            default: begin
            end
         endcase
      end
      // hardware set wins over a software clear in the same cycle
      if (xfer_i.valid && xfer_i.setup_token && !st_ff.host_enable) begin
         nxt_st.packet_halt = 1'b1;
      end
      // token sequencer
      case (st_ff.tok_state)
         uocs_pkg::UOCS_TK_IDLE: begin
         end
         uocs_pkg::UOCS_TK_RUN: begin
            if (token_done_i) begin
               nxt_st.tok_state = uocs_pkg::UOCS_TK_DONE;
            end
         end
         uocs_pkg::UOCS_TK_DONE: begin
            nxt_st.tok_state = uocs_pkg::UOCS_TK_IDLE;
         end
         default: begin
            nxt_st.tok_state = uocs_pkg::UOCS_TK_IDLE;
         end
      endcase
      if (!st_ff.host_enable) begin
         nxt_st.tok_state = uocs_pkg::UOCS_TK_IDLE;
      end
      // frame timer runs only in host mode with frame enable set, not while suspended
      if (st_ff.host_enable && st_ff.attach_or_sof && !st_ff.suspend_enable) begin
         if (st_ff.frame_cnt == 17'(`UOCS_FRAME_CYC - 1)) begin
            nxt_st.frame_cnt = 17'h00000;
            nxt_st.sof_pulse = 1'b1;
         end else begin
            nxt_st.frame_cnt = st_ff.frame_cnt + 17'h00001;
         end
      end else begin
         nxt_st.frame_cnt = 17'h00000;
      end
      // read mux, registered
      if (rd) begin
         case (wb_adr_i)
            `UOCS_OFS_PWRC: nxt_st.rdata = {24'h000000, act_pend, 2'b00, st_ff.sleep_guard,
                                            2'b00, st_ff.suspend_enable, st_ff.power_enable};
            `UOCS_OFS_STAT: nxt_st.rdata = {24'h000000, st_ff.last_endpoint,
                                            st_ff.last_transmit, st_ff.last_odd, 2'b00};
            `UOCS_OFS_CON: nxt_st.rdata = {24'h000000, live_live_idle_state_flag, live_se0,
                                           (st_ff.host_enable ? tok_busy : st_ff.packet_halt),
                                           st_ff.host_enable & st_ff.bus_reset,
                                           st_ff.host_enable, st_ff.resume, 1'b0,
                                           st_ff.attach_or_sof};
            `UOCS_OFS_ADDR: nxt_st.rdata = {24'h000000, st_ff.host_enable & st_ff.low_speed,
                                            st_ff.function_address};
            `UOCS_OFS_TOK: nxt_st.rdata = {24'h000000, st_ff.token_pid, st_ff.token_endpoint};
            `UOCS_OFS_SOF: nxt_st.rdata = {24'h000000, st_ff.threshold};
            `UOCS_OFS_LINK: nxt_st.rdata = {30'h00000000, engine_busy_i, token_done_i};
            default: nxt_st.rdata = 32'h00000000;
         endcase
      end
   end

   // single state register; clock enable freezes everything
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
         st_ff.threshold <= `UOCS_SOF_RST;
         st_ff.tok_state <= uocs_pkg::UOCS_TK_IDLE;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // outputs
   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = st_ff.rdata;
   assign activity_pending_o = act_pend;
   assign token_in_progress_o = tok_busy;
   assign frame_threshold_o = st_ff.threshold;
   // pulls follow host/attach bits unless dual-role control overrides them
   always_comb begin
      ctl_o = '0;
      ctl_o.clock_gate = st_ff.suspend_enable || !st_ff.power_enable;
      ctl_o.xcvr_low_power = st_ff.suspend_enable;
      ctl_o.dp_pulldown = !dual_role_enable_i && st_ff.host_enable;
      ctl_o.dm_pulldown = !dual_role_enable_i && st_ff.host_enable;
      ctl_o.dp_pullup = !dual_role_enable_i && !st_ff.host_enable && st_ff.power_enable &&
                        st_ff.attach_or_sof;
      ctl_o.resume_drive = st_ff.resume;
      ctl_o.bus_reset_drive = st_ff.host_enable && st_ff.bus_reset;
      ctl_o.packet_halt = !st_ff.host_enable && st_ff.packet_halt;
      ctl_o.low_speed = st_ff.host_enable && st_ff.low_speed;
      ctl_o.pingpong_clear = st_ff.pp_clear;
      ctl_o.sof_pulse = st_ff.sof_pulse;
   end
   always_comb begin
      tok_o.start = st_ff.tok_start;
      tok_o.pid = st_ff.token_pid;
      tok_o.endpoint = st_ff.token_endpoint;
      tok_o.address = st_ff.function_address;
   end
endmodule : uocs_top
`default_nettype wire

// ==== verif/uocs_top_asserts.sv ====
/* port checker of the otg control block.
   assumes binding to uocs_top; one clock domain. */
`default_nettype none
module uocs_top_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire uocs_pkg::uocs_xfer_s xfer_i,
   input wire logic token_done_i,
   input wire logic dual_role_enable_i,
   input wire uocs_pkg::uocs_ctl_s ctl_o,
   input wire uocs_pkg::uocs_tok_s tok_o,
   input wire logic [7:0] frame_threshold_o,
   input wire logic token_in_progress_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // bus answers exactly one cycle after the request is taken
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   low_power_gate_a: assert property (ctl_o.xcvr_low_power |-> ctl_o.clock_gate)
      else $error("low power without gate");
   pulldown_pair_a: assert property (!dual_role_enable_i |-> ctl_o.dp_pulldown == ctl_o.dm_pulldown)
      else $error("pull-downs differ");
   setup_halt_a: assert property (xfer_i.valid && xfer_i.setup_token && !ctl_o.dp_pulldown
      && !dual_role_enable_i |=> ctl_o.packet_halt) else $error("halt not set");
   // a token starts only from the write that names it
   start_cause_a: assert property (tok_o.start |-> wb_ack_o && wb_we_i && wb_adr_i == 8'h10
      && tok_o.pid == wb_dat_i[7:4] && tok_o.endpoint == wb_dat_i[3:0]) else $error("bad start");
   busy_start_a: assert property (tok_o.start |-> token_in_progress_o ##1 !tok_o.start)
      else $error("busy missing");
   busy_release_a: assert property (token_done_i && token_in_progress_o
      |-> ##[2:3] !token_in_progress_o) else $error("busy stuck");
   pp_pulse_a: assert property (ctl_o.pingpong_clear |=> !ctl_o.pingpong_clear)
      else $error("clear held");
   threshold_write_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h14
      |-> frame_threshold_o == wb_dat_i[7:0]) else $error("threshold lost");
endmodule : uocs_top_asserts
`default_nettype wire

// ==== verif/uocs_engine_model.sv ====
/* serial engine model: answers a token lat plus one cycles after it samples the start, reports transfers.
   assumes the block's token outputs; inj forces a device-side report. */
`default_nettype none
module uocs_engine_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire uocs_pkg::uocs_tok_s tok,
   input wire logic [7:0] lat,
   input wire uocs_pkg::uocs_xfer_s inj,
   output uocs_pkg::uocs_xfer_s xfer,
   output logic busy,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   logic odd;
   uocs_pkg::uocs_xfer_s rep;
   // bank alternates per transfer, as a ping-pong endpoint would
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 8'h00;
         busy <= 1'b0;
         done <= 1'b0;
         odd <= 1'b0;
         rep <= '0;
      end else begin
         done <= 1'b0;
         rep.valid <= 1'b0;
         if (tok.start) begin
            busy <= 1'b1;
            cnt <= lat;
         end else if (busy && cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
         end else if (busy) begin
            busy <= 1'b0;
            done <= 1'b1;
            odd <= !odd;
            rep <= {1'b1, tok.endpoint, tok.pid != 4'h9, odd, tok.pid == 4'hd};
         end
      end
   end
   // forced report wins; the bench never lets both coincide
   assign xfer = inj.valid ? inj : rep;
endmodule : uocs_engine_model
`default_nettype wire

// ==== verif/uocs_top_tb.sv ====
/* bench of the otg control block: wishbone master tasks and register tests.
   assumes the engine model and the port checker beside it. */
`default_nettype none
module uocs_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic req = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic ack, busy, done, tip, act;
   logic pp_seen = 1'b0;
   logic [7:0] lat = 8'h01;
   logic [7:0] q, thr;
   logic [3:0] pids [3] = '{4'hd, 4'h9, 4'h1};
   uocs_pkg::uocs_xfer_s inj = '0;
   uocs_pkg::uocs_xfer_s xfer;
   uocs_pkg::uocs_line_s line = '0;
   uocs_pkg::uocs_ctl_s ctl;
   uocs_pkg::uocs_tok_s tok;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc_cnt = 0;
   always #5 clk = ~clk;
   // one pin tie each for clock enable, byte lane and dual-role
   uocs_top DUT (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .wb_adr_i(adr), .wb_dat_i(wd),
      .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(4'h1), .wb_cyc_i(req), .wb_stb_i(req),
      .wb_ack_o(ack), .xfer_i(xfer), .line_i(line), .engine_busy_i(busy),
      .token_done_i(done), .dual_role_enable_i(1'b0), .ctl_o(ctl), .tok_o(tok),
      .frame_threshold_o(thr), .token_in_progress_o(tip), .activity_pending_o(act));
   uocs_engine_model u_eng (.clk(clk), .rst_n(rst_n), .tok(tok), .lat(lat), .inj(inj),
      .xfer(xfer), .busy(busy), .done(done));
   task automatic final_report();
      if (mismatches == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chkb(input string nm, input logic e, input logic g);
      chk(nm, {7'h00, e}, {7'h00, g});
   endtask : chkb
   // classic cycle: hold until ack is sampled, then one idle cycle
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      adr <= a;
      we <= w;
      wd <= {24'h000000, d};
      req <= 1'b1;
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat[7:0];
      req <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(a, 1'b1, d);
   endtask : wr
   task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      chk(nm, e, q);
   endtask : rd
   // the clear pulse lasts one cycle, so it is latched here
   always @(posedge clk) begin
      if (ctl.pingpong_clear === 1'b1)
         pp_seen <= 1'b1;
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         mismatches++;
         final_report();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chkb("gate", 1'b1, ctl.clock_gate);
      rd("unmapped", 8'h1c, 8'h00);
      wr(8'h00, 8'h13);
      rd("power", 8'h00, 8'h13);
      chkb("lowpwr", 1'b1, ctl.xcvr_low_power);
      wr(8'h00, 8'h11);
      chkb("gate", 1'b0, ctl.clock_gate);
      wr(8'h0c, 8'hff);
      rd("addr", 8'h0c, 8'h7f);
      wr(8'h08, 8'h01);
      chkb("pullup", 1'b1, ctl.dp_pullup);
      line.se0 <= 1'b1;
      rd("ctl", 8'h08, 8'h41);
      line.se0 <= 1'b0;
      inj <= {1'b1, 4'hf, 1'b0, 1'b1, 1'b1};
      @(posedge clk);
      inj <= '0;
      @(posedge clk);
      chkb("halt", 1'b1, ctl.packet_halt);
      rd("stat", 8'h04, 8'hf4);
      wr(8'h08, 8'h03);
      chkb("ppclr", 1'b1, pp_seen);
      rd("ctl", 8'h08, 8'h01);
      wr(8'h08, 8'h08);
      chkb("pulldn", 1'b1, ctl.dp_pulldown);
      chkb("pulldn_m", 1'b1, ctl.dm_pulldown);
      wr(8'h0c, 8'h85);
      rd("addr", 8'h0c, 8'h85);
      chkb("lspd", 1'b1, ctl.low_speed);
      rd("ctl", 8'h08, 8'h88);
      wr(8'h0c, 8'h05);
      rd("ctl", 8'h08, 8'h08);
      line.diff_one <= 1'b1;
      wr(8'h08, 8'h1c);
      chkb("busrst", 1'b1, ctl.bus_reset_drive);
      chkb("resume", 1'b1, ctl.resume_drive);
      wr(8'h08, 8'h08);
      wr(8'h14, 8'h4a);
      chk("thr", 8'h4a, thr);
      // every token code, slow answer in the middle, endpoints up to 15
      for (int i = 0; i < 3; i++) begin
         lat <= (i == 1) ? 8'h28 : 8'h01;
         wr(8'h10, {pids[i], 4'(i + 13)});
         chkb("busy", 1'b1, tip);
         chk("tokaddr", 8'h05, {1'b0, tok.address});
         chkb("act", 1'b1, act);
         rd("ctl", 8'h08, 8'ha8);
         while (tip !== 1'b0) @(posedge clk);
         rd("stat", 8'h04, {4'(i + 13), pids[i] != 4'h9, i[0], 2'b00});
         chkb("act", 1'b0, act);
      end
      wr(8'h08, 8'h00);
      wr(8'h00, 8'h00);
      chkb("gate", 1'b1, ctl.clock_gate);
      final_report();
   end
endmodule : uocs_top_tb
bind uocs_top uocs_top_asserts u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .xfer_i(xfer_i),
   .token_done_i(token_done_i), .dual_role_enable_i(dual_role_enable_i), .ctl_o(ctl_o),
   .tok_o(tok_o), .frame_threshold_o(frame_threshold_o),
   .token_in_progress_o(token_in_progress_o));
`default_nettype wire
